/* File: inc/gps_pkg.sv */
package gps_pkg;
    localparam int NPORT = 3;
    localparam int NPIN  = 24;
    localparam int NFN   = 7;

    // Register byte offsets: port p sits at p * PORT_STRIDE
    localparam logic [7:0] PORT_STRIDE = 8'h08;
    localparam logic [2:0] OFS_DIR     = 3'h0;
    localparam logic [2:0] OFS_LEVEL   = 3'h1;
    localparam logic [2:0] OFS_LATCH   = 3'h2;
    localparam logic [2:0] OFS_ANLG    = 3'h3;
    localparam logic [2:0] OFS_WPU     = 3'h4;
    localparam logic [7:0] OFS_STEER   = 8'h20;

    // Reset values
    localparam logic [7:0] RST_DIR     = 8'hFF;
    localparam logic [7:0] RST_LATCH   = 8'h00;
    localparam logic [7:0] RST_WPU     = 8'h00;
    localparam logic [6:0] RST_STEER   = 7'h00;

    // Implemented analog and pull-up bits per port (A, B, C)
    localparam logic [NPORT-1:0][7:0] ANLG_MASK = {8'h00, 8'h3F, 8'h2F};
    localparam logic [NPORT-1:0][7:0] WPU_MASK  = {8'h00, 8'hFF, 8'h00};

    // Steering field positions
    localparam int FN_CAPTURE2 = 0;
    localparam int FN_CLIENT   = 1;
    localparam int FN_COMP2    = 2;
    localparam int FN_LATCHINV = 3;
    localparam int FN_PWM2B    = 4;
    localparam int FN_TGATE    = 5;
    localparam int FN_CAPTURE3 = 6;

    // Pin index = port * 8 + bit; listed from function 6 down to 0
    localparam logic [NFN-1:0][4:0] FN_DEF_PIN =
        {5'h16, 5'h0D, 5'h10, 5'h05, 5'h05, 5'h05, 5'h11};
    localparam logic [NFN-1:0][4:0] FN_ALT_PIN =
        {5'h0D, 5'h14, 5'h0D, 5'h00, 5'h00, 5'h00, 5'h0B};
endpackage

/* File: verilog/gps_sync.sv */
`timescale 1ns/1ps
module gps_sync
    import gps_pkg::*;
#(
    parameter int W = NPIN
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* File: verilog/gps_port.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// How it works
// R1: Each port has direction, level, latch registers
// R2: Some ports add analog select, pull-up registers
// R3: Enabled peripheral pin ignores latch, still readable
// R4: Level write updates latch, same as latch write
// R5: Latch reads latch; level reads actual pins
// R6: Analog bit disables pin's digital input buffer
// R7: Steering routes seven functions between alternate pins
// R8: Steering writes never change direction registers
// R9: Peripheral overrides follow the selected pin
// R10: Unselected pin keeps plain port behaviour
// R11: Software clears level, latch, analog, then direction
// R12: Direction one is input, zero drives latch
// R13: Analog pins read digital zero
// R14: Analog setting does not affect digital output
// R15: Analog bits reset to analog
// R16: Pin inputs pass two synchroniser flops
// R17: Steering register resets to zero
module gps_port
    import gps_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            arst_n_i,
    // Register port
    input  wire logic [7:0]      addr_i,
    input  wire logic [7:0]      wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [7:0]      rdata_o,
    // Pins
    input  wire logic [NPIN-1:0] pad_i,
    output logic      [NPIN-1:0] pad_o,
    output logic      [NPIN-1:0] pad_oe_o,
    output logic      [NPIN-1:0] pullup_o,
    output logic      [NPIN-1:0] din_en_o,
    // Steerable peripheral functions
    input  wire logic [NFN-1:0]  fn_en_i,
    input  wire logic [NFN-1:0]  fn_oe_i,
    input  wire logic [NFN-1:0]  fn_out_i,
    output logic      [NFN-1:0]  fn_in_o
);
    logic [7:0]      dir   [NPORT];
    logic [7:0]      latch [NPORT];
    logic [7:0]      anlg  [NPORT];
    logic [7:0]      wpu   [NPORT];
    logic [6:0]      steer;
    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] anlg_flat;
    logic [NPIN-1:0] pin_dig;
    logic [NPIN-1:0] ovr_en;
    logic [NPIN-1:0] ovr_oe;
    logic [NPIN-1:0] ovr_val;
    logic [NPIN-1:0] next_pad;
    logic [NPIN-1:0] next_oe;

    // Pin currently carrying function f
    function automatic logic [4:0] fn_pin(input logic [6:0] s, input int f);
        return s[f] ? FN_ALT_PIN[f] : FN_DEF_PIN[f];
    endfunction

    function automatic logic hit(input logic [7:0] a, input int p, input logic [2:0] o);
        return a == 8'((p * PORT_STRIDE) + o);
    endfunction

    gps_sync #(
        .W(NPIN)
    ) u_sync (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .d_i     (pad_i),
        .q_o     (pin_sync)
    );

    // Register writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int p = 0; p < NPORT; p++) begin
                dir[p]   <= RST_DIR;
                latch[p] <= RST_LATCH;
                anlg[p]  <= ANLG_MASK[p]; // R15
                wpu[p]   <= RST_WPU;
            end
        end else if (wr_i) begin
            for (int p = 0; p < NPORT; p++) begin
                if (hit(addr_i, p, OFS_DIR)) begin
                    dir[p] <= wdata_i; // R1
                end
                if (hit(addr_i, p, OFS_LEVEL) || hit(addr_i, p, OFS_LATCH)) begin
                    latch[p] <= wdata_i; // R4
                end
                if (hit(addr_i, p, OFS_ANLG)) begin
                    anlg[p] <= wdata_i & ANLG_MASK[p]; // R2
                end
                if (hit(addr_i, p, OFS_WPU)) begin
                    wpu[p] <= wdata_i & WPU_MASK[p]; // R2
                end
            end
        end
    end

    // Steering owns no direction state, so it cannot disturb it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            steer <= RST_STEER; // R17
        end else if (wr_i && addr_i == OFS_STEER) begin
            steer <= wdata_i[6:0]; // R7 R8
        end
    end

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            anlg_flat[p*8 +: 8] = anlg[p];
        end
        pin_dig = pin_sync & ~anlg_flat; // R13 R16
    end

    // Peripheral overrides land on the selected pin only
    always_comb begin
        ovr_en  = '0;
        ovr_oe  = '0;
        ovr_val = '0;
        for (int f = 0; f < NFN; f++) begin
            if (fn_en_i[f]) begin
                ovr_en[fn_pin(steer, f)]  = 1'b1; // R9 R10
                ovr_oe[fn_pin(steer, f)]  = fn_oe_i[f];
                ovr_val[fn_pin(steer, f)] = fn_out_i[f];
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                next_oe[p*8+b]  = ovr_en[p*8+b] ? ovr_oe[p*8+b] : ~dir[p][b]; // R3 R12
                next_pad[p*8+b] = ovr_en[p*8+b] ? ovr_val[p*8+b] : latch[p][b]; // R14
            end
        end
    end

    // Pin-side outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_o    <= '0;
            pad_oe_o <= '0;
            pullup_o <= '0;
            din_en_o <= '0;
        end else begin
            pad_o    <= next_pad;
            pad_oe_o <= next_oe;
            // Pull-up only on a released pin, never against our own driver
            pullup_o <= ~next_oe & {wpu[2], wpu[1], wpu[0]}; // R2
            din_en_o <= ~anlg_flat; // R6
        end
    end

    // Function inputs sample their selected pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fn_in_o <= '0;
        end else begin
            for (int f = 0; f < NFN; f++) begin
                fn_in_o[f] <= pin_dig[fn_pin(steer, f)]; // R7 R9
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= 8'h00;
            if (rd_i) begin
                if (addr_i == OFS_STEER) begin
                    rdata_o <= {1'b0, steer};
                end
                for (int p = 0; p < NPORT; p++) begin
                    if (hit(addr_i, p, OFS_DIR)) begin
                        rdata_o <= dir[p];
                    end
                    if (hit(addr_i, p, OFS_LEVEL)) begin
                        rdata_o <= pin_dig[p*8 +: 8]; // R5 R3
                    end
                    if (hit(addr_i, p, OFS_LATCH)) begin
                        rdata_o <= latch[p]; // R5
                    end
                    if (hit(addr_i, p, OFS_ANLG)) begin
                        rdata_o <= anlg[p];
                    end
                    if (hit(addr_i, p, OFS_WPU)) begin
                        rdata_o <= wpu[p];
                    end
                end
            end
        end
    end

    AST_LEVEL_WRITES_LATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
        wr_i && addr_i == 8'(OFS_LEVEL) |=> latch[0] == $past(wdata_i))
        else $error("Level write did not update latch");

    AST_STEER_KEEPS_DIR: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R8
        wr_i && addr_i == OFS_STEER |=> dir[0] == $past(dir[0]) && dir[1] == $past(dir[1]))
        else $error("Steering write changed direction");

    AST_ANALOG_READS_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R13
        rd_i && addr_i == 8'(OFS_LEVEL) |=> (rdata_o & $past(anlg[0])) == 8'h00)
        else $error("Analog pin read nonzero");

    AST_INPUT_DRIVER_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R12
        !ovr_en[3] && dir[0][3] |=> !pad_oe_o[3])
        else $error("Input pin driver on");

    AST_ANALOG_STILL_DRIVES: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R14
        !ovr_en[1] && !dir[0][1] |=> pad_oe_o[1] && pad_o[1] == $past(latch[0][1]))
        else $error("Output pin not driving latch");

    AST_PERIPH_ON_DEFAULT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
        fn_en_i[FN_PWM2B] && !steer[FN_PWM2B] && !fn_en_i[FN_CAPTURE3]
        |=> pad_o[16] == $past(fn_out_i[FN_PWM2B]) && pad_oe_o[16] == $past(fn_oe_i[FN_PWM2B]))
        else $error("Peripheral override missing on selected pin");

    AST_UNSELECTED_PLAIN: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R10
        !steer[FN_CAPTURE2] && !dir[1][3] |=> pad_oe_o[11] && pad_o[11] == $past(latch[1][3]))
        else $error("Unselected pin disturbed");

    AST_LEVEL_TWO_FLOPS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
        rd_i && addr_i == 8'(PORT_STRIDE + 8'(OFS_LEVEL)) && anlg[1] == 8'h00
        ##1 $stable(anlg[1]) |-> rdata_o == $past(pad_i[15:8], 3))
        else $error("Level read latency wrong");

    // Register map
    AST_LATCH_WRITES_LATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
        wr_i && addr_i == 8'(OFS_LATCH) |=> latch[0] == $past(wdata_i))
        else $error("Latch write did not land");

    AST_DIR_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R1
        wr_i && addr_i == 8'(OFS_DIR) |=> dir[0] == $past(wdata_i))
        else $error("Direction write did not land");

    AST_DIR_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R1
        rd_i && addr_i == 8'(OFS_DIR) |=> rdata_o == $past(dir[0]))
        else $error("Direction read wrong");

    AST_LATCH_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
        rd_i && addr_i == 8'(OFS_LATCH) |=> rdata_o == $past(latch[0]))
        else $error("Latch read wrong");

    AST_LEVEL_READS_PINS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
        rd_i && addr_i == 8'(OFS_LEVEL)
        |=> rdata_o == ($past(pin_sync[7:0]) & ~$past(anlg[0])))
        else $error("Level read not from pins");

    AST_READ_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
        !rd_i |=> rdata_o == 8'h00)
        else $error("Read data held too long");

    AST_ANALOG_WRITE_MASKED: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
        wr_i && addr_i == 8'(2 * PORT_STRIDE + 8'(OFS_ANLG)) |=> anlg[2] == 8'h00)
        else $error("Absent analog bits took a write");

    AST_PULLUP_ONLY_PORT_B: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
        wr_i && addr_i == 8'(OFS_WPU) |=> wpu[0] == 8'h00)
        else $error("Absent pull-up bits took a write");

    AST_PULLUP_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
        wr_i && addr_i == 8'(PORT_STRIDE + 8'(OFS_WPU)) |=> wpu[1] == $past(wdata_i))
        else $error("Pull-up write did not land");

    AST_STEER_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R7
        wr_i && addr_i == OFS_STEER |=> steer == $past(wdata_i[6:0]))
        else $error("Steering write did not land");

    // Pin path
    AST_BUFFER_OFF_ANALOG: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R6
        1'b1 |=> din_en_o == ~$past(anlg_flat))
        else $error("Input buffer not following analog select");

    AST_PULLUP_RELEASED: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
        1'b1 |=> (pullup_o & pad_oe_o) == 24'h00_0000)
        else $error("Pull-up on a driven pin");

    // Pin 13 is also the timer gate default and the capture3 alternate
    AST_PERIPH_ON_ALT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R3
        fn_en_i[FN_PWM2B] && steer[FN_PWM2B] && !fn_en_i[FN_TGATE] && !fn_en_i[FN_CAPTURE3]
        |=> pad_o[13] == $past(fn_out_i[FN_PWM2B]) && pad_oe_o[13] == $past(fn_oe_i[FN_PWM2B]))
        else $error("Peripheral override missing on alternate pin");

    AST_TGATE_ON_ALT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
        steer[FN_TGATE] |=> fn_in_o[FN_TGATE] == $past(pin_dig[20]))
        else $error("Gate input not from alternate pin");

    AST_TGATE_ON_DEFAULT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R7
        !steer[FN_TGATE] |=> fn_in_o[FN_TGATE] == $past(pin_dig[13]))
        else $error("Gate input not from default pin");

    AST_SYNC_TWO_FLOPS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
        1'b1 |-> ##2 pin_sync == $past(pad_i, 2))
        else $error("Pin synchroniser depth wrong");

    // Reset values, seen on the first edge after release
    AST_STEER_RESET: assert property (@(posedge clk_i) // R17
        $rose(arst_n_i) |-> steer == RST_STEER)
        else $error("Steering not cleared by reset");

    AST_ANALOG_RESET: assert property (@(posedge clk_i) // R15
        $rose(arst_n_i)
        |-> anlg[0] == ANLG_MASK[0] && anlg[1] == ANLG_MASK[1] && anlg[2] == ANLG_MASK[2])
        else $error("Analog select not set by reset");
endmodule

/* File: dv/gps_pins.sv */
`timescale 1ns/1ps
module gps_pins
    import gps_pkg::*;
(
    // Design side
    input  wire logic [NPIN-1:0] pad_o_i,
    input  wire logic [NPIN-1:0] oe_i,
    input  wire logic [NPIN-1:0] pu_i,
    // Outside world
    input  wire logic [NPIN-1:0] ext_i,
    output logic      [NPIN-1:0] pad_i_o
);
    // Driver wins; a released pin with pull-up floats high
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pad_i_o[i] = oe_i[i] ? pad_o_i[i] : (pu_i[i] ? 1'b1 : ext_i[i]);
        end
    end
endmodule

/* File: dv/test_gps_port.sv */
`timescale 1ns/1ps
module test_gps_port;
    import gps_pkg::*;
    logic            clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0;
    logic [7:0]      addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rv;
    logic [NPIN-1:0] pad_i, pad_o, pad_oe_o, pullup_o, din_en_o, ext = 24'h00_0000;
    logic [NFN-1:0]  fn_en_i = 7'h00, fn_oe_i = 7'h00, fn_out_i = 7'h00, fn_in_o;
    int              errors = 0, compares = 0, cycles = 0;

    gps_port dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_i(pad_i), .pad_o(pad_o),
        .pad_oe_o(pad_oe_o), .pullup_o(pullup_o), .din_en_o(din_en_o), .fn_en_i(fn_en_i),
        .fn_oe_i(fn_oe_i), .fn_out_i(fn_out_i), .fn_in_o(fn_in_o));
    gps_pins pins (.pad_o_i(pad_o), .oe_i(pad_oe_o), .pu_i(pullup_o), .ext_i(ext),
        .pad_i_o(pad_i));

    always #5 clk_i = ~clk_i;
    // Whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        for (int p = 0; p < NPORT; p++) begin
            rd_reg(8'(p * 8) + 8'h00, rv); chk(rv, 8'hFF);
            rd_reg(8'(p * 8) + 8'h02, rv); chk(rv, 8'h00);
            rd_reg(8'(p * 8) + 8'h03, rv); chk(rv, ANLG_MASK[p]);
            rd_reg(8'(p * 8) + 8'h04, rv); chk(rv, 8'h00);
        end
        rd_reg(8'h20, rv); chk(rv, 8'h00);
        rd_reg(8'h30, rv); chk(rv, 8'h00);
        wr_reg(8'h0C, 8'hFF);
        settle();
        chk(pullup_o[15:8], 8'hFF);
    endtask
    task automatic t_init();
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h02, 8'h00);
        wr_reg(8'h03, 8'h00);
        wr_reg(8'h00, 8'h38);
        wr_reg(8'h01, 8'h55);
        rd_reg(8'h02, rv); chk(rv, 8'h55);
        settle();
        chk(pad_oe_o[7:0], 8'hC7);
        chk(din_en_o[7:0], 8'hFF);
        rd_reg(8'h01, rv); chk(rv, 8'h45);
        ext[5:3] = 3'b111;
        settle();
        rd_reg(8'h01, rv); chk(rv, 8'h7D);
    endtask
    task automatic t_analog();
        wr_reg(8'h03, 8'h2F);
        settle();
        chk(din_en_o[7:0], 8'hD0);
        rd_reg(8'h01, rv); chk(rv, 8'h50);
        chk({5'h00, pad_o[2:0]}, 8'h05);
        chk({5'h00, pad_oe_o[2:0]}, 8'h07);
    endtask
    // Port B as outputs; pwm2b still steered onto B5 and drives it high
    task automatic t_portb();
        wr_reg(8'h0B, 8'h00);
        wr_reg(8'h0A, 8'h85);
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h04, 8'hFF);
        wr_reg(8'h13, 8'hFF);
        settle();
        rd_reg(8'h09, rv); chk(rv, 8'hA5);
        rd_reg(8'h0A, rv); chk(rv, 8'h85);
        chk(pullup_o[15:8], 8'h00);
        chk({6'h00, pad_oe_o[11], pad_o[11]}, 8'h02);
        rd_reg(8'h04, rv); chk(rv, 8'h00);
        rd_reg(8'h13, rv); chk(rv, 8'h00);
    endtask
    // Reset in mid-run must restore every register
    task automatic t_rerun();
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk(din_en_o[7:0], ~ANLG_MASK[0]);
        chk(pad_oe_o[15:8], 8'h00);
        t_reset();
    endtask
    task automatic t_steer();
        wr_reg(8'h10, 8'h00);
        fn_en_i[FN_PWM2B] <= 1'b1;
        fn_oe_i[FN_PWM2B] <= 1'b1;
        fn_out_i[FN_PWM2B] <= 1'b1;
        settle();
        chk({6'h00, pad_oe_o[16], pad_o[16]}, 8'h03);
        rd_reg(8'h11, rv); chk(rv, 8'h01);
        wr_reg(8'h20, 8'h30);
        settle();
        chk({6'h00, pad_oe_o[13], pad_o[13]}, 8'h03);
        chk({6'h00, pad_oe_o[16], pad_o[16]}, 8'h02);
        rd_reg(8'h10, rv); chk(rv, 8'h00);
        rd_reg(8'h08, rv); chk(rv, 8'hFF);
        rd_reg(8'h20, rv); chk(rv, 8'h30);
        wr_reg(8'h12, 8'h10);
        settle();
        chk({7'h00, fn_in_o[FN_TGATE]}, 8'h01);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_init();
        t_analog();
        t_steer();
        t_portb();
        t_rerun();
        give_verdict();
    end
endmodule
